// *** src/rpbl_defs.svh ***
`ifndef RPBL_DEFS_SVH
`define RPBL_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RPBL_A_PLL 8'h00
`define RPBL_A_STAT 8'h04
`define RPBL_A_LEN 8'h08
`define RPBL_A_CRC 8'h0c

// ****************************************
// Field positions
// ****************************************
`define RPBL_PLL_R_LSB 0
`define RPBL_PLL_F_LSB 8
`define RPBL_PLL_OD_LSB 24
`define RPBL_STAT_ERR 8
`define RPBL_STAT_RUN 9
`define RPBL_STAT_OTP 10
`define RPBL_STAT_SEL_LSB 12
`define RPBL_SEC_BOOT_BIT 5

// ****************************************
// Boot PLL settings per clock select
// ****************************************
`define RPBL_OD_BOOT 3'h1
`define RPBL_R_BOOT 6'h00
`define RPBL_F_SEL00 12'h09f
`define RPBL_F_SEL11 12'h03f
`define RPBL_F_SEL10 12'h01f
`define RPBL_F_SEL01 12'h00f

// ****************************************
// Image and check constants
// ****************************************
`define RPBL_CRC_POLY 32'hedb88320
`define RPBL_CRC_INIT 32'hffffffff
`define RPBL_CRC_SKIP 32'h0d15ab1e
`define RPBL_RAM_BASE 16'h0000
`define RPBL_OTP_BASE 16'h0000

// ****************************************
// Timing
// ****************************************
`define RPBL_CLK_MHZ 25
`define RPBL_BOOT_DLY_US 15
`define RPBL_BOOT_DLY_CYC (`RPBL_BOOT_DLY_US * `RPBL_CLK_MHZ)

`endif

// *** src/rpbl_pkg.sv ***
package rpbl_pkg;

  // ****************************************
  // Boot sequencer states, one-hot
  // ****************************************
  typedef enum logic [7:0] {
    RPBL_ST_RESET = 8'h01,
    RPBL_ST_DELAY = 8'h02,
    RPBL_ST_LEN = 8'h04,
    RPBL_ST_PROG = 8'h08,
    RPBL_ST_CHK = 8'h10,
    RPBL_ST_FLUSH = 8'h20,
    RPBL_ST_RUN = 8'h40,
    RPBL_ST_ERR = 8'h80
  } rpbl_state_t;

  // PLL divider fields
  typedef struct packed {
    logic [2:0] od;
    logic [11:0] f;
    logic [5:0] r;
  } rpbl_pll_t;

endpackage : rpbl_pkg

// *** src/rpbl_stream_if.sv ***
`timescale 1ns/1ps

// Word stream with valid and ready
interface rpbl_stream_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rpbl_stream_if

// *** src/rpbl_buf.sv ***
`timescale 1ns/1ps

// Two-entry word buffer between image parser and RAM port
module rpbl_buf (
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Streams
  rpbl_stream_if.snk s_in,
  rpbl_stream_if.src s_out
);

  logic [31:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  wire push = s_in.valid & s_in.ready;
  wire pop = s_out.valid & s_out.ready;

  // Handshake and data
  assign s_in.ready = (cnt_q != 2'h2);
  assign s_out.valid = (cnt_q != 2'h0);
  assign s_out.data = mem_q[rp_q];

  // Storage
  always_ff @(posedge i_core_clk) begin
    if (i_ce && push) begin
      mem_q[wp_q] <= s_in.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_ce) begin
      wp_q <= wp_q ^ push;
      rp_q <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : rpbl_buf

// *** src/rpbl_top.sv ***
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rpbl_defs.svh"

module rpbl_top (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Chip pins
  input wire logic i_chip_rst_n,
  input wire logic [1:0] i_clk_sel,
  output logic o_gpio_pulldown,
  // Secure configuration word
  input wire logic [31:0] i_secure_cfg,
  // Boot source byte stream
  output logic o_src_req,
  output logic o_src_otp,
  output logic [15:0] o_src_addr,
  input wire logic i_src_valid,
  input wire logic [7:0] i_src_byte,
  output logic o_src_ready,
  // RAM write port
  output logic o_ram_we,
  output logic [15:0] o_ram_addr,
  output logic [31:0] o_ram_wdata,
  input wire logic i_ram_ready,
  // Core start and status
  output logic o_core_start,
  output logic [15:0] o_start_addr,
  output logic o_running,
  output logic o_boot_err,
  // PLL setting
  output logic [2:0] o_pll_output_divider,
  output logic [11:0] o_pll_mult,
  output logic [5:0] o_pll_in_div,
  output logic [12:0] o_pll_ratio_num,
  output logic [12:0] o_pll_ratio_den,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp
);

  // ****************************************
  // CRC step
  // ****************************************
  // One byte, least significant bit first, reflected form
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ b[i]) ? ((x >> 1) ^ `RPBL_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_byte

  // ****************************************
  // State
  // ****************************************
  rpbl_pkg::rpbl_state_t st_q;
  rpbl_pkg::rpbl_state_t st_d;
  rpbl_pkg::rpbl_pll_t pll_q;
  rpbl_pkg::rpbl_pll_t pll_boot;
  logic [8:0] dly_q;
  logic [1:0] bcnt_q;
  logic [23:0] sh_q;
  logic [31:0] len_q;
  logic [31:0] wcnt_q;
  logic [31:0] crc_q;
  logic ok_q;
  logic otp_q;
  logic start_q;
  logic [15:0] ramad_q;
  logic ap_wr_q;
  logic [7:0] ap_adr_q;
  logic [31:0] rdata_q;

  rpbl_stream_if buf_in ();
  rpbl_stream_if buf_out ();

  // ****************************************
  // Decode
  // ****************************************
  // State flags
  wire in_reset = (st_q == rpbl_pkg::RPBL_ST_RESET);
  wire in_delay = (st_q == rpbl_pkg::RPBL_ST_DELAY);
  wire in_len = (st_q == rpbl_pkg::RPBL_ST_LEN);
  wire in_prog = (st_q == rpbl_pkg::RPBL_ST_PROG);
  wire in_chk = (st_q == rpbl_pkg::RPBL_ST_CHK);
  wire in_flush = (st_q == rpbl_pkg::RPBL_ST_FLUSH);
  wire in_run = (st_q == rpbl_pkg::RPBL_ST_RUN);
  wire in_err = (st_q == rpbl_pkg::RPBL_ST_ERR);

  // Byte stream handshake and word assembly
  wire src_rdy = in_len | in_chk | (in_prog & buf_in.ready);
  wire beat = i_src_valid & src_rdy;
  wire last_byte = (bcnt_q == 2'h3);
  wire word_done = beat & last_byte;
  wire [31:0] word_w = {i_src_byte, sh_q};
  wire crc_take = beat & (in_len | in_prog);
  wire [31:0] crc_next = crc_byte(crc_q, i_src_byte);
  wire last_word = (wcnt_q == len_q - 32'h1);
  wire dly_done = (dly_q == 9'(`RPBL_BOOT_DLY_CYC - 1));
  wire crc_match = (word_w == `RPBL_CRC_SKIP) | (word_w == ~crc_q);

  // Boot PLL setting from clock-select pins
  wire [11:0] f_boot = (i_clk_sel == 2'h0) ? `RPBL_F_SEL00 :
                       (i_clk_sel == 2'h3) ? `RPBL_F_SEL11 :
                       (i_clk_sel == 2'h2) ? `RPBL_F_SEL10 : `RPBL_F_SEL01;
  assign pll_boot = '{od: `RPBL_OD_BOOT, f: f_boot, r: `RPBL_R_BOOT};

  // Bus decode
  wire ap_take = i_hsel & i_htrans[1] & i_hready;
  wire pll_wr = ap_wr_q & (ap_adr_q == `RPBL_A_PLL);
  wire [31:0] pll_word = ({29'h0, pll_q.od} << `RPBL_PLL_OD_LSB) |
                         ({20'h0, pll_q.f} << `RPBL_PLL_F_LSB) |
                         ({26'h0, pll_q.r} << `RPBL_PLL_R_LSB);
  wire [31:0] stat_word = {24'h0, st_q} |
                          ({31'h0, in_err} << `RPBL_STAT_ERR) |
                          ({31'h0, in_run} << `RPBL_STAT_RUN) |
                          ({31'h0, otp_q} << `RPBL_STAT_OTP) |
                          ({30'h0, i_clk_sel} << `RPBL_STAT_SEL_LSB);
  wire [31:0] rd_mux = (i_haddr == `RPBL_A_PLL) ? pll_word :
                       (i_haddr == `RPBL_A_STAT) ? stat_word :
                       (i_haddr == `RPBL_A_LEN) ? len_q :
                       (i_haddr == `RPBL_A_CRC) ? ~crc_q : 32'h0;

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      rpbl_pkg::RPBL_ST_RESET: begin
        st_d = rpbl_pkg::RPBL_ST_DELAY;
      end
      rpbl_pkg::RPBL_ST_DELAY: begin
        if (dly_done) begin
          st_d = rpbl_pkg::RPBL_ST_LEN;
        end
      end
      rpbl_pkg::RPBL_ST_LEN: begin
        if (word_done) begin
          st_d = (word_w == 32'h0) ? rpbl_pkg::RPBL_ST_CHK : rpbl_pkg::RPBL_ST_PROG;
        end
      end
      rpbl_pkg::RPBL_ST_PROG: begin
        if (word_done && last_word) begin
          st_d = rpbl_pkg::RPBL_ST_CHK;
        end
      end
      rpbl_pkg::RPBL_ST_CHK: begin
        if (word_done) begin
          st_d = rpbl_pkg::RPBL_ST_FLUSH;
        end
      end
      rpbl_pkg::RPBL_ST_FLUSH: begin
        if (!buf_out.valid) begin
          st_d = ok_q ? rpbl_pkg::RPBL_ST_RUN : rpbl_pkg::RPBL_ST_ERR;
        end
      end
      rpbl_pkg::RPBL_ST_RUN, rpbl_pkg::RPBL_ST_ERR: begin
        st_d = st_q; // Terminal until reset
      end
      default: begin
        st_d = rpbl_pkg::RPBL_ST_RESET;
      end
    endcase
    if (!i_chip_rst_n) begin
      st_d = rpbl_pkg::RPBL_ST_RESET;
    end
  end

  // State register, start pulse and post-reset delay count
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= rpbl_pkg::RPBL_ST_RESET;
      start_q <= 1'b0;
      dly_q <= 9'h000;
    end else if (i_ce) begin
      st_q <= st_d;
      start_q <= (st_d == rpbl_pkg::RPBL_ST_RUN) & ~in_run;
      dly_q <= in_delay ? dly_q + 9'h001 : 9'h000;
    end
  end

  // Boot source choice caught at reset release
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      otp_q <= 1'b0;
    end else if (i_ce && in_reset) begin
      otp_q <= i_secure_cfg[`RPBL_SEC_BOOT_BIT];
    end
  end

  // ****************************************
  // Image parser
  // ****************************************
  // Byte gathering, lowest byte first
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bcnt_q <= 2'h0;
      sh_q <= 24'h0;
    end else if (i_ce) begin
      if (in_delay) begin
        bcnt_q <= 2'h0;
      end else if (beat) begin
        bcnt_q <= bcnt_q + 2'h1;
        sh_q <= {i_src_byte, sh_q[23:8]};
      end
    end
  end

  // Length, word count and verdict
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      len_q <= 32'h0;
      wcnt_q <= 32'h0;
      ok_q <= 1'b0;
    end else if (i_ce) begin
      if (in_delay) begin
        wcnt_q <= 32'h0;
        ok_q <= 1'b0;
      end else if (word_done && in_len) begin
        len_q <= word_w;
      end else if (word_done && in_prog) begin
        wcnt_q <= wcnt_q + 32'h1;
      end else if (word_done && in_chk) begin
        ok_q <= crc_match;
      end
    end
  end

  // Running CRC over length and program bytes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      crc_q <= `RPBL_CRC_INIT;
    end else if (i_ce) begin
      if (in_delay) begin
        crc_q <= `RPBL_CRC_INIT;
      end else if (crc_take) begin
        crc_q <= crc_next;
      end
    end
  end

  // ****************************************
  // Word buffer and RAM port
  // ****************************************
  assign buf_in.valid = in_prog & word_done;
  assign buf_in.data = word_w;
  assign buf_out.ready = i_ram_ready;

  rpbl_buf rpbl_buf_inst (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .s_in(buf_in.snk),
    .s_out(buf_out.src)
  );

  // RAM word address from the bottom
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ramad_q <= `RPBL_RAM_BASE;
    end else if (i_ce) begin
      if (in_delay) begin
        ramad_q <= `RPBL_RAM_BASE;
      end else if (buf_out.valid && i_ram_ready) begin
        ramad_q <= ramad_q + 16'h0001;
      end
    end
  end

  // ****************************************
  // PLL configuration
  // ****************************************
  // Boot value while in reset, software value after
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pll_q <= '{od: `RPBL_OD_BOOT, f: `RPBL_F_SEL00, r: `RPBL_R_BOOT};
    end else if (i_ce) begin
      if (in_reset) begin
        pll_q <= pll_boot;
      end else if (pll_wr) begin
        pll_q.od <= i_hwdata[`RPBL_PLL_OD_LSB +: 3];
        pll_q.f <= i_hwdata[`RPBL_PLL_F_LSB +: 12];
        pll_q.r <= i_hwdata[`RPBL_PLL_R_LSB +: 6];
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Address phase capture and read data
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ap_wr_q <= 1'b0;
      ap_adr_q <= 8'h00;
      rdata_q <= 32'h0;
    end else if (i_ce) begin
      ap_wr_q <= ap_take & i_hwrite;
      ap_adr_q <= i_haddr;
      if (ap_take && !i_hwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_hrdata = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_gpio_pulldown = in_reset;
  assign o_src_req = in_len | in_prog | in_chk;
  assign o_src_otp = otp_q;
  assign o_src_addr = `RPBL_OTP_BASE;
  assign o_src_ready = src_rdy;
  assign o_ram_we = buf_out.valid;
  assign o_ram_addr = ramad_q;
  assign o_ram_wdata = buf_out.data;
  assign o_core_start = start_q;
  assign o_start_addr = `RPBL_RAM_BASE;
  assign o_running = in_run;
  assign o_boot_err = in_err;
  assign o_pll_output_divider = pll_q.od;
  assign o_pll_mult = pll_q.f;
  assign o_pll_in_div = pll_q.r;
  assign o_pll_ratio_num = {1'b0, pll_q.f} + 13'h0001;
  assign o_pll_ratio_den = ({6'h00, pll_q.r, 1'b0} + 13'h0002) *
                           ({10'h000, pll_q.od} + 13'h0001);

endmodule : rpbl_top

// *** bench/rpbl_top_asserts.sv ***
`timescale 1ns/1ps

// ****
// Boot loader port checks
// ****
module rpbl_top_asserts (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Watched ports
  input wire logic i_chip_rst_n,
  input wire logic [1:0] i_clk_sel,
  input wire logic i_ram_ready,
  input wire logic o_gpio_pulldown,
  input wire logic o_src_req,
  input wire logic o_src_ready,
  input wire logic o_ram_we,
  input wire logic [15:0] o_ram_addr,
  input wire logic [31:0] o_ram_wdata,
  input wire logic o_core_start,
  input wire logic [15:0] o_start_addr,
  input wire logic o_running,
  input wire logic o_boot_err,
  input wire logic [2:0] o_pll_output_divider,
  input wire logic [11:0] o_pll_mult,
  input wire logic [5:0] o_pll_in_div,
  input wire logic [12:0] o_pll_ratio_num,
  input wire logic [12:0] o_pll_ratio_den
);
  localparam int DLY_MIN = 374;
  localparam int DLY_MAX = 3750;
  logic [15:0] dly_q;
  logic [15:0] dly_d;
  logic [11:0] mult_exp;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Boot multiplier per select code, cycles out of reset
  assign mult_exp = (i_clk_sel == 2'h0) ? 12'h09f : (i_clk_sel == 2'h3) ? 12'h03f :
                    (i_clk_sel == 2'h2) ? 12'h01f : 12'h00f;
  assign dly_d = o_gpio_pulldown ? 16'h0000 : dly_q + {15'h0000, dly_q != 16'hffff};
  always_ff @(posedge i_core_clk) begin
    dly_q <= i_srst ? 16'h0000 : dly_d;
  end

  chk_pin_pulldown: assert property (!i_chip_rst_n |-> ##[1:2] o_gpio_pulldown)
    else $error("pull-down off in chip reset");
  chk_boot_pll: assert property (o_gpio_pulldown && $past(o_gpio_pulldown) |->
    o_pll_mult == $past(mult_exp) && o_pll_output_divider == 3'h1 && o_pll_in_div == 6'h00)
    else $error("boot PLL fields wrong");
  chk_pll_ratio: assert property (o_pll_ratio_num == o_pll_mult + 13'h0001 &&
    o_pll_ratio_den == 13'h0002 * (o_pll_in_div + 13'h0001) * (o_pll_output_divider + 13'h0001))
    else $error("PLL ratio wrong");
  chk_boot_delay: assert property ($rose(o_src_req) |-> dly_q >= DLY_MIN && dly_q <= DLY_MAX)
    else $error("boot delay out of range");
  chk_ram_hold: assert property (o_ram_we && !i_ram_ready |=> o_ram_we
    && $stable(o_ram_wdata) && $stable(o_ram_addr))
    else $error("RAM write dropped");
  chk_ram_step: assert property (o_ram_we && i_ram_ready |=>
    o_ram_addr == $past(o_ram_addr) + 16'h0001)
    else $error("RAM address did not step");
  chk_start_pulse: assert property (o_core_start |-> o_running && o_start_addr == 16'h0000
    ##1 !o_core_start)
    else $error("start pulse wrong");
  chk_start_seen: assert property ($rose(o_running) |-> ##[0:1] o_core_start)
    else $error("no start pulse");
  chk_err_sticky: assert property (o_boot_err && i_chip_rst_n |=> o_boot_err && !o_running)
    else $error("boot error not held");
  chk_ready_state: assert property (o_src_ready |-> o_src_req)
    else $error("source ready outside load");

  cov_run: cover property (o_core_start);
  cov_err: cover property ($rose(o_boot_err));
  cov_stall: cover property (o_ram_we && !i_ram_ready);
endmodule : rpbl_top_asserts

// *** bench/rpbl_src_model.sv ***
`timescale 1ns/1ps

// ****
// Boot byte source
// ****
module rpbl_src_model (
  // Clock and handshake
  input wire logic i_core_clk,
  input wire logic i_req,
  input wire logic i_ready,
  // Byte out
  output logic o_valid,
  output logic [7:0] o_byte
);
  logic [7:0] q[$];
  initial o_valid = 1'b0;
  initial o_byte = 8'h5a;

  // Offers queued bytes in order with random gaps; idle shows inverted data
  always @(posedge i_core_clk) begin
    if (o_valid && i_ready) begin
      void'(q.pop_front());
    end
    if (!o_valid || i_ready) begin
      if (i_req && q.size() > 0 && $urandom_range(3) != 0) begin
        o_valid <= 1'b1;
        o_byte <= q[0];
      end else begin
        o_valid <= 1'b0;
        o_byte <= ~o_byte;
      end
    end
  end
endmodule : rpbl_src_model

// *** bench/rpbl_top_bench.sv ***
`timescale 1ns/1ps
`include "rpbl_defs.svh"

// ****
// Boot loader bench
// ****
module rpbl_top_bench;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_chip_rst_n = 1'b0;
  logic [1:0] i_clk_sel = 2'h0, i_htrans = 2'h0;
  logic [31:0] i_secure_cfg = 32'h0, i_hwdata = 32'h0, o_ram_wdata, o_hrdata;
  logic i_src_valid, i_ram_ready = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, stall = 1'b0;
  logic [7:0] i_src_byte, i_haddr = 8'h00;
  logic [2:0] i_hsize = 3'h2, o_pll_output_divider;
  logic o_gpio_pulldown, o_src_req, o_src_otp, o_src_ready, o_ram_we, o_core_start;
  logic o_running, o_boot_err, o_hreadyout, o_hresp;
  logic [15:0] o_src_addr, o_ram_addr, o_start_addr;
  logic [11:0] o_pll_mult;
  logic [5:0] o_pll_in_div;
  logic [12:0] o_pll_ratio_num, o_pll_ratio_den;
  logic [31:0] exp_q[$];
  int wi = 0, bad_count = 0, check_count = 0;

  rpbl_top rpbl_top_inst (.i_core_clk, .i_srst, .i_ce, .i_chip_rst_n, .i_clk_sel,
    .o_gpio_pulldown, .i_secure_cfg, .o_src_req, .o_src_otp, .o_src_addr, .i_src_valid,
    .i_src_byte, .o_src_ready, .o_ram_we, .o_ram_addr, .o_ram_wdata, .i_ram_ready,
    .o_core_start, .o_start_addr, .o_running, .o_boot_err, .o_pll_output_divider, .o_pll_mult,
    .o_pll_in_div, .o_pll_ratio_num, .o_pll_ratio_den, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp);
  rpbl_src_model src_inst (.i_core_clk, .i_req(o_src_req), .i_ready(o_src_ready),
    .o_valid(i_src_valid), .o_byte(i_src_byte));

  // Clock, RAM acceptance and RAM write monitor
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    i_ram_ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
    if (o_ram_we && i_ram_ready) begin
      chk("ram_addr", {16'h0000, o_ram_addr}, wi);
      chk("ram_data", o_ram_wdata, exp_q[wi]);
      wi++;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 32'hedb88320 : r >> 1;
    return r;
  endfunction : crc8

  function automatic logic [11:0] fmul(input logic [1:0] s);
    return (s == 2'h0) ? 12'h09f : (s == 2'h3) ? 12'h03f : (s == 2'h2) ? 12'h01f : 12'h00f;
  endfunction : fmul

  // Single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    chk("hresp", {31'h0, o_hresp}, 32'h0);
  endtask : ahb

  // Queue one word, low byte first, folding it into the CRC
  task automatic pw(input logic [31:0] w, inout logic [31:0] c);
    for (int k = 0; k < 4; k++) begin
      src_inst.q.push_back(w[8*k +: 8]);
      c = crc8(c, w[8*k +: 8]);
    end
  endtask : pw

  // One boot: kind 0 good check word, 1 skip value, 2 bad check word
  task automatic boot(input logic [1:0] s, input int n, input int kind);
    logic [31:0] c, w, cfg, rd;
    int cnt;
    cfg = $urandom;
    exp_q.delete();
    i_chip_rst_n <= 1'b0;
    i_clk_sel <= s;
    i_secure_cfg <= cfg;
    repeat (4) @(posedge i_core_clk);
    chk("boot_mult", o_pll_mult, fmul(s));
    chk("pulldown", o_gpio_pulldown, 1'b1);
    c = 32'hffffffff;
    pw(n, c);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      exp_q.push_back(w);
      pw(w, c);
    end
    w = (kind == 1) ? 32'h0d15ab1e : (kind == 2) ? c : ~c;
    src_inst.q.push_back(w[7:0]);
    src_inst.q.push_back(w[15:8]);
    src_inst.q.push_back(w[23:16]);
    src_inst.q.push_back(w[31:24]);
    wi = 0;
    i_chip_rst_n <= 1'b1;
    cnt = 0;
    while (o_src_req !== 1'b1 && cnt < 5000) begin
      @(posedge i_core_clk);
      cnt++;
    end
    chk("boot_delay", cnt >= 375 && cnt <= 3751, 1'b1);
    chk("src_otp", o_src_otp, cfg[5]);
    chk("src_addr", o_src_addr, 16'h0000);
    if (n == 6) begin
      stall <= 1'b1;
      repeat (40) @(posedge i_core_clk);
      chk("stall_ready", o_src_ready, 1'b0);
      stall <= 1'b0;
    end
    cnt = 0;
    while (o_running !== 1'b1 && o_boot_err !== 1'b1 && cnt < 5000) begin
      @(posedge i_core_clk);
      cnt++;
    end
    repeat (2) @(posedge i_core_clk);
    chk("boot_err", o_boot_err, kind == 2);
    chk("running", o_running, kind != 2);
    chk("words", wi, n);
    chk("start_addr", o_start_addr, 16'h0000);
    ahb(1'b1, `RPBL_A_LEN, 32'($urandom), rd);
    ahb(1'b0, `RPBL_A_LEN, 32'h0, rd);
    chk("len_reg", rd, n);
    ahb(1'b0, `RPBL_A_CRC, 32'h0, rd);
    chk("crc_reg", rd, ~c);
    ahb(1'b0, `RPBL_A_STAT, 32'h0, rd);
    chk("stat_reg", rd, {18'h0, s, 1'b0, cfg[5], kind != 2, kind == 2,
        (kind == 2) ? 8'h80 : 8'h40});
  endtask : boot

  // PLL rewrite by software, unmapped read
  task automatic regs();
    logic [31:0] w, rd;
    w = {5'h00, 3'($urandom), 4'h0, 12'($urandom), 2'h0, 6'($urandom)};
    ahb(1'b1, `RPBL_A_PLL, w, rd);
    ahb(1'b0, `RPBL_A_PLL, 32'h0, rd);
    chk("pll_reg", rd, w);
    chk("pll_pins", {o_pll_output_divider, o_pll_mult, o_pll_in_div},
        {w[26:24], w[19:8], w[5:0]});
    chk("ratio_num", o_pll_ratio_num, w[19:8] + 1);
    chk("ratio_den", o_pll_ratio_den, 2 * (w[5:0] + 1) * (w[26:24] + 1));
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // Write while clock enable is low must not land
    i_ce <= 1'b0;
    ahb(1'b1, `RPBL_A_PLL, ~w, rd);
    i_ce <= 1'b1;
    ahb(1'b0, `RPBL_A_PLL, 32'h0, rd);
    chk("pll_frozen", rd, w);
  endtask : regs

  initial begin
    void'($urandom(32'hed60752d));
    repeat (16) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    chk("reset_pll", {o_pll_output_divider, o_pll_mult, o_pll_in_div},
        {3'h1, 12'h09f, 6'h00});
    // Chip reset held 1 ms after supply good
    repeat (1000 * `RPBL_CLK_MHZ) @(posedge i_core_clk);
    boot(2'h0, 3, 0);
    regs();
    boot(2'h1, 0, 1);
    boot(2'h2, 6, 0);
    boot(2'h3, 2, 2);
    boot(2'($urandom), 1 + $urandom_range(7), 0);
    end_of_test();
  end

  // Watchdog
  initial begin
    #(40 * 60000);
    bad_count++;
    end_of_test();
  end
endmodule : rpbl_top_bench

bind rpbl_top rpbl_top_asserts rpbl_top_asserts_inst (.i_core_clk, .i_srst, .i_chip_rst_n,
  .i_clk_sel, .i_ram_ready, .o_gpio_pulldown, .o_src_req, .o_src_ready, .o_ram_we, .o_ram_addr,
  .o_ram_wdata, .o_core_start, .o_start_addr, .o_running, .o_boot_err, .o_pll_output_divider,
  .o_pll_mult, .o_pll_in_div, .o_pll_ratio_num, .o_pll_ratio_den);
